// ---- hw/power_mode_and_strap_control.sv ----
// Power mode controller with strap latch and host registers
// ********************************************
// ********************************************
`timescale 1ns/10ps
module power_mode_and_strap_control import pm_pkg::*; #(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic bus_width_strap_pin_in,
  output logic bus_width_strap_pin_out,
  output logic bus_width_strap_pin_oe_n,
  input wire logic eeprom_strap_pin_in,
  output logic eeprom_strap_pin_out,
  output logic eeprom_strap_pin_oe_n,
  input wire logic endian_strap_pin_in,
  output logic endian_strap_pin_out,
  output logic endian_strap_pin_oe_n,
  input wire logic led_drive,
  input wire logic eeprom_data_drive,
  input wire logic eeprom_clock_drive,
  input wire logic energy_present,
  input wire logic pll_locked,
  input wire logic autoneg_enabled,
  input wire logic cable_link_up,
  input wire logic power_save_ctrl_bit,
  output logic pll_enable,
  output logic phy_enable,
  output logic mac_enable,
  output logic host_enable,
  output logic energy_sense_only,
  output logic rx_unused_off,
  output logic traffic_enable,
  output logic power_event_output,
  output logic energy_irq,
  output logic bus_is_16bit,
  output logic eeprom_present,
  output logic big_endian
);

  typedef struct packed {
    pm_state_t st;
    logic ret_ed;
    logic straps_done;
    logic event_flag;
    logic [15:0] power_management_event_control;
    logic [15:0] interrupt_enable;
    logic [15:0] receive_frame_pointer;
    logic [15:0] sleep_wake_timing;
    logic [15:0] global_reset_control;
    logic [15:0] chip_configuration;
    logic [15:0] rdata;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic awake;
  logic timer_run;
  logic [7:0] timer_limit;
  logic timer_expired;
  logic wake_cmd;
  logic [2:0] strap_drive;
  logic [2:0] strap_out;
  logic [2:0] strap_oe_n;

  // ********************************************
  // Parameter check
  // ********************************************
  generate
    if (TICKS < 2) begin : g_bad_ticks
      $error("power_mode_and_strap_control: TICKS must be at least 2");
    end
  endgenerate

  // ********************************************
  // Sleep and wake interval timing
  // ********************************************
  // One idle cycle after each expiry restarts the count, so the wake
  // interval never inherits what is left of the go-sleep count
  assign timer_run = ((s_q.st == ST_ED_AWAKE && !energy_present) ||
                      (s_q.st == ST_ED_SLEEP && energy_present)) && !timer_expired;
  assign timer_limit = (s_q.st == ST_ED_SLEEP) ? s_q.sleep_wake_timing[15:8] : s_q.sleep_wake_timing[7:0];

  interval_timer #(
    .TICKS(TICKS)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(timer_run),
    .limit(timer_limit),
    .expired(timer_expired)
  );

  // ********************************************
  // Awake decode and wake command
  // ********************************************
  // Blocks that keep running clocks and accept host cycles
  assign awake = (s_q.st == ST_NORMAL) || (s_q.st == ST_POWER_SAVE) ||
                 (s_q.st == ST_ED_AWAKE);

  // Read of the global reset register, seen even while the host side sleeps
  assign wake_cmd = reg_rd_en && (reg_addr == OFS_GLOBAL_RESET_CONTROL);

  // ********************************************
  // Mode decode and register read
  // ********************************************
  function automatic pm_state_t mode_state(input logic [1:0] m);
    case (m)
      MODE_NORMAL: mode_state = ST_NORMAL;
      MODE_ENERGY_DETECT: mode_state = ST_ED_AWAKE;
      MODE_SOFT_DOWN: mode_state = ST_SOFT_DOWN;
      MODE_POWER_SAVE: mode_state = ST_POWER_SAVE;
      default: mode_state = ST_NORMAL;
    endcase
  endfunction

  function automatic logic [15:0] reg_read(input ctrl_state_t s, input logic [7:0] a);
    case (a)
      OFS_GLOBAL_RESET_CONTROL: reg_read = s.global_reset_control;
      OFS_INTERRUPT_ENABLE: reg_read = s.interrupt_enable;
      OFS_POWER_MANAGEMENT_EVENT_CONTROL: reg_read = s.power_management_event_control;
      OFS_CHIP_CONFIGURATION: reg_read = s.chip_configuration;
      OFS_RECEIVE_FRAME_POINTER: reg_read = s.receive_frame_pointer;
      OFS_SLEEP_WAKE_TIMING: reg_read = s.sleep_wake_timing;
      // Unmapped offsets read as zero
      default: reg_read = '0;
    endcase
  endfunction

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;

    // Capture in the first cycle after release, before pins turn round
    if (!s_q.straps_done) begin
      s_d.straps_done = 1'b1;
      s_d.chip_configuration[CCR_BUS16_BIT] = bus_width_strap_pin_in;
      s_d.chip_configuration[CCR_BUS8_BIT] = !bus_width_strap_pin_in;
      s_d.chip_configuration[CCR_EEPROM_BIT] = eeprom_strap_pin_in;
      s_d.chip_configuration[CCR_BIG_ENDIAN_BIT] = endian_strap_pin_in;
    end

    // Host reads; the global reset read doubles as the wake command
    if (reg_rd_en && awake) begin
      s_d.rdata = reg_read(s_q, reg_addr);
    end
    if (wake_cmd) begin
      if (s_q.st == ST_ED_SLEEP && !s_q.power_management_event_control[PMC_AUTO_WAKE_BIT]) begin
        s_d.st = ST_PLL_WAIT;
        s_d.ret_ed = 1'b1;
      end else if (s_q.st == ST_SOFT_DOWN) begin
        s_d.st = ST_PLL_WAIT;
        s_d.ret_ed = 1'b0;
      end
    end

    // Host writes, ignored while the host interface is gated
    if (reg_wr_en && awake) begin
      case (reg_addr)
        OFS_GLOBAL_RESET_CONTROL: s_d.global_reset_control = reg_wdata;
        OFS_INTERRUPT_ENABLE: s_d.interrupt_enable = reg_wdata;
        OFS_RECEIVE_FRAME_POINTER: s_d.receive_frame_pointer = reg_wdata;
        OFS_SLEEP_WAKE_TIMING: s_d.sleep_wake_timing = reg_wdata;
        OFS_POWER_MANAGEMENT_EVENT_CONTROL: begin
          s_d.power_management_event_control = reg_wdata;
          s_d.power_management_event_control[PMC_EVENT_BIT] = s_q.event_flag && !reg_wdata[PMC_EVENT_BIT];
          s_d.event_flag = s_q.event_flag && !reg_wdata[PMC_EVENT_BIT];
          s_d.st = mode_state(reg_wdata[1:0]);
        end
        default: s_d.st = s_q.st;
      endcase
    end

    // Hardware transitions come after the host, so an event wins a clear
    case (s_q.st)
      ST_ED_AWAKE: begin
        if (timer_expired) begin
          s_d.st = ST_ED_SLEEP;
        end
      end
      ST_ED_SLEEP: begin
        if (timer_expired) begin
          s_d.event_flag = 1'b1;
          s_d.power_management_event_control[PMC_EVENT_BIT] = 1'b1;
          if (s_q.power_management_event_control[PMC_AUTO_WAKE_BIT]) begin
            s_d.st = ST_PLL_WAIT;
            s_d.ret_ed = 1'b1;
          end else if (s_q.power_management_event_control[PMC_TO_NORMAL_BIT]) begin
            s_d.st = ST_PLL_WAIT;
            s_d.ret_ed = 1'b0;
          end
        end
      end
      ST_PLL_WAIT: begin
        // MAC and PHY wait for lock, so nothing runs on a ragged clock
        if (pll_locked) begin
          s_d.st = s_q.ret_ed ? ST_ED_AWAKE : ST_NORMAL;
          if (!s_q.ret_ed) begin
            s_d.power_management_event_control[1:0] = MODE_NORMAL;
          end
        end
      end
      ST_NORMAL, ST_POWER_SAVE, ST_SOFT_DOWN: begin
        s_d.ret_ed = s_q.ret_ed;
      end
      default: begin
        s_d.st = ST_NORMAL;
      end
    endcase
  end

  // ********************************************
  // State register
  // ********************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= ST_NORMAL;
      s_q.ret_ed <= 1'b0;
      s_q.straps_done <= 1'b0;
      s_q.event_flag <= 1'b0;
      s_q.power_management_event_control <= REG_RESET;
      s_q.interrupt_enable <= REG_RESET;
      s_q.receive_frame_pointer <= REG_RESET;
      s_q.sleep_wake_timing <= REG_RESET;
      s_q.global_reset_control <= REG_RESET;
      s_q.chip_configuration <= REG_RESET;
      s_q.rdata <= REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************
  // Block gating and pin outputs
  // ********************************************
  assign reg_rdata = s_q.rdata;
  assign pll_enable = (s_q.st != ST_ED_SLEEP) && (s_q.st != ST_SOFT_DOWN);
  assign phy_enable = awake && pll_locked;
  assign mac_enable = awake && pll_locked;
  assign host_enable = awake;
  assign energy_sense_only = (s_q.st == ST_ED_SLEEP);
  assign rx_unused_off = (s_q.st == ST_POWER_SAVE) && autoneg_enabled &&
                         !cable_link_up && power_save_ctrl_bit;
  assign traffic_enable = awake && pll_locked && !rx_unused_off;

  // ********************************************
  // Event and strap status
  // ********************************************
  assign power_event_output = s_q.event_flag && s_q.power_management_event_control[PMC_PME_EN_BIT];
  assign energy_irq = s_q.event_flag && s_q.interrupt_enable[IER_ENERGY_BIT];
  assign bus_is_16bit = s_q.chip_configuration[CCR_BUS16_BIT];
  assign eeprom_present = s_q.chip_configuration[CCR_EEPROM_BIT];
  assign big_endian = s_q.chip_configuration[CCR_BIG_ENDIAN_BIT] || s_q.receive_frame_pointer[RFP_ENDIAN_BIT];

  // ********************************************
  // Strap pins, one slice per pin
  // ********************************************
  // Slice 0 bus width, 1 EEPROM presence, 2 endian
  assign strap_drive = {eeprom_clock_drive, eeprom_data_drive, led_drive};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_strap
      // Pins stay inputs until the straps are held, then serve as outputs
      assign strap_oe_n[i] = !s_q.straps_done;
      assign strap_out[i] = s_q.straps_done && strap_drive[i];
    end
  endgenerate

  assign bus_width_strap_pin_oe_n = strap_oe_n[0];
  assign eeprom_strap_pin_oe_n = strap_oe_n[1];
  assign endian_strap_pin_oe_n = strap_oe_n[2];
  assign bus_width_strap_pin_out = strap_out[0];
  assign eeprom_strap_pin_out = strap_out[1];
  assign endian_strap_pin_out = strap_out[2];

endmodule

// ---- hw/pm_pkg.sv ----
// Constants and types for the power mode and strap controller
package pm_pkg;

  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [7:0] OFS_GLOBAL_RESET_CONTROL = 8'h26;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h90;
  localparam logic [7:0] OFS_POWER_MANAGEMENT_EVENT_CONTROL = 8'hd4;
  localparam logic [7:0] OFS_CHIP_CONFIGURATION = 8'h08;
  localparam logic [7:0] OFS_RECEIVE_FRAME_POINTER = 8'h86;
  localparam logic [7:0] OFS_SLEEP_WAKE_TIMING = 8'ha6;

  // ********************************************
  // Field positions
  // ********************************************
  localparam int CCR_BUS8_BIT = 7;
  localparam int CCR_BUS16_BIT = 6;
  localparam int CCR_EEPROM_BIT = 9;
  localparam int CCR_BIG_ENDIAN_BIT = 10;
  localparam int RFP_ENDIAN_BIT = 11;
  localparam int PMC_EVENT_BIT = 2;
  localparam int PMC_TO_NORMAL_BIT = 6;
  localparam int PMC_AUTO_WAKE_BIT = 7;
  localparam int PMC_PME_EN_BIT = 8;
  localparam int IER_ENERGY_BIT = 2;

  // ********************************************
  // Mode codes and reset values
  // ********************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY_DETECT = 2'h1;
  localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
  localparam logic [1:0] MODE_POWER_SAVE = 2'h3;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ********************************************
  // Timing
  // ********************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_NORMAL = 6'b000001,
    ST_POWER_SAVE = 6'b000010,
    ST_ED_AWAKE = 6'b000100,
    ST_ED_SLEEP = 6'b001000,
    ST_SOFT_DOWN = 6'b010000,
    ST_PLL_WAIT = 6'b100000
  } pm_state_t;

endpackage

// ---- hw/interval_timer.sv ----
// Tick divider and interval counter for the sleep and wake timing
`timescale 1ns/10ps
module interval_timer import pm_pkg::*; #(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] limit,
  output logic expired
);

  localparam int DW = (TICKS > 2) ? $clog2(TICKS) : 1;

  generate
    if (TICKS < 2) begin : g_bad
      $error("interval_timer: TICKS must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DW-1:0] div;
    logic [8:0] cnt;
    logic expired;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;
  logic tick;

  // ********************************************
  // Free-running timebase, kept alive while the PLL is off
  // ********************************************
  always_comb begin
    s_d = s_q;
    tick = (s_q.div == DW'(TICKS - 1));
    s_d.div = tick ? '0 : s_q.div + 1'b1;
    s_d.expired = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (tick && (s_q.cnt <= {1'b0, limit})) begin
      // Counter stops past the limit, so one interval fires once
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.expired = (s_q.cnt == {1'b0, limit});
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule

// ---- test/pm_board_model.sv ----
// Board model: strap resistors, pin resolution and PLL lock delay
`timescale 1ns/10ps
module pm_board_model (
  input wire logic clk,
  input wire logic pll_enable,
  input wire logic [2:0] strap_level,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  output logic [2:0] pin_level,
  output logic pll_locked
);
  logic [2:0] lock_q = 3'h0;
  // Resistor sets the level only while the device floats the pin
  assign pin_level = (pin_oe_n & strap_level) | (~pin_oe_n & pin_out);
  // Lock comes late after enable, so a premature MAC enable shows
  always_ff @(posedge clk) begin
    lock_q <= pll_enable ? {lock_q[1:0], 1'b1} : 3'h0;
  end
  assign pll_locked = lock_q[2] & pll_enable;
endmodule

// ---- test/pm_ctrl_sva.sv ----
// Port assertions for the power mode and strap controller
`timescale 1ns/10ps
module pm_ctrl_sva import pm_pkg::*; #(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic bus_width_strap_pin_oe_n,
  input wire logic autoneg_enabled,
  input wire logic cable_link_up,
  input wire logic power_save_ctrl_bit,
  input wire logic pll_locked,
  input wire logic pll_enable,
  input wire logic phy_enable,
  input wire logic mac_enable,
  input wire logic host_enable,
  input wire logic energy_sense_only,
  input wire logic rx_unused_off,
  input wire logic traffic_enable,
  input wire logic power_event_output,
  input wire logic bus_is_16bit,
  input wire logic eeprom_present
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  pll_off_host_a: assert property (!pll_enable |-> !host_enable && !phy_enable)
    else $error("host or phy on with pll stopped");
  phy_lock_a: assert property (phy_enable |-> pll_locked)
    else $error("phy on before pll lock");
  mac_phy_a: assert property (mac_enable == phy_enable)
    else $error("mac and phy gating differ");
  traffic_gate_a: assert property (traffic_enable |-> host_enable && pll_locked && !rx_unused_off)
    else $error("traffic outside normal power state");
  sense_only_a: assert property (energy_sense_only |-> !pll_enable && !host_enable && !mac_enable)
    else $error("circuits on in low power state");
  save_cond_a: assert property (rx_unused_off |->
    (autoneg_enabled && !cable_link_up && power_save_ctrl_bit) ||
    $past(autoneg_enabled && !cable_link_up && power_save_ctrl_bit))
    else $error("receiver off without its conditions");
  strap_out_a: assert property ($past(rst_n) |-> !bus_width_strap_pin_oe_n)
    else $error("strap pin not an output after reset");
  strap_hold_a: assert property ($past(rst_n, 2) |-> $stable(bus_is_16bit) && $stable(eeprom_present))
    else $error("latched strap changed after reset");
  soft_wake_a: assert property (reg_rd_en && reg_addr == OFS_GLOBAL_RESET_CONTROL && !pll_enable &&
    !energy_sense_only |=> pll_enable && !host_enable)
    else $error("global reset read did not restart pll");
  cover property (rx_unused_off);
  cover property (energy_sense_only ##1 !energy_sense_only);
  cover property ($rose(power_event_output));
endmodule
bind power_mode_and_strap_control pm_ctrl_sva #(.TICKS(TICKS)) sva (.clk, .rst_n, .reg_addr,
  .reg_rd_en, .bus_width_strap_pin_oe_n, .autoneg_enabled, .cable_link_up, .power_save_ctrl_bit,
  .pll_locked, .pll_enable, .phy_enable, .mac_enable, .host_enable, .energy_sense_only,
  .rx_unused_off, .traffic_enable, .power_event_output, .bus_is_16bit, .eeprom_present);

// ---- test/tb_power_mode_and_strap_control.sv ----
// Testbench for the power mode and strap controller
`timescale 1ns/10ps
module tb_power_mode_and_strap_control import pm_pkg::*;;
  localparam int TK = 4;
  localparam logic [7:0] PMC = OFS_POWER_MANAGEMENT_EVENT_CONTROL;
  logic clk, rst_n, reg_wr_en, reg_rd_en, energy_present, pll_locked, autoneg_enabled;
  logic cable_link_up, power_save_ctrl_bit, led_drive, eeprom_data_drive, eeprom_clock_drive;
  logic pll_enable, phy_enable, mac_enable, host_enable, energy_sense_only, rx_unused_off;
  logic traffic_enable, power_event_output, energy_irq, bus_is_16bit, eeprom_present, big_endian;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] strap, pin_lv, pin_o, pin_oe;
  int fail_count = 0;
  int num_checks = 0;
  power_mode_and_strap_control #(.TICKS(TK)) dut (.clk, .rst_n, .reg_addr, .reg_wr_en,
    .reg_rd_en, .reg_wdata, .reg_rdata, .bus_width_strap_pin_in(pin_lv[0]),
    .bus_width_strap_pin_out(pin_o[0]), .bus_width_strap_pin_oe_n(pin_oe[0]),
    .eeprom_strap_pin_in(pin_lv[1]), .eeprom_strap_pin_out(pin_o[1]),
    .eeprom_strap_pin_oe_n(pin_oe[1]), .endian_strap_pin_in(pin_lv[2]),
    .endian_strap_pin_out(pin_o[2]), .endian_strap_pin_oe_n(pin_oe[2]), .led_drive,
    .eeprom_data_drive, .eeprom_clock_drive, .energy_present, .pll_locked, .autoneg_enabled,
    .cable_link_up, .power_save_ctrl_bit, .pll_enable, .phy_enable, .mac_enable, .host_enable,
    .energy_sense_only, .rx_unused_off, .traffic_enable, .power_event_output, .energy_irq,
    .bus_is_16bit, .eeprom_present, .big_endian);
  pm_board_model board (.clk, .pll_enable, .strap_level(strap), .pin_out(pin_o),
    .pin_oe_n(pin_oe), .pin_level(pin_lv), .pll_locked);
  // ********************************************
  // Host access and checking
  // ********************************************
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] exp);
    rd(a);
    chk(nm, reg_rdata, exp);
  endtask
  // Bounded wait: 0 low power, 1 power event, else host interface up
  task automatic wt(input int s);
    logic x;
    for (int n = 0; n < 400; n++) begin
      @(negedge clk);
      x = (s == 0) ? energy_sense_only : (s == 1) ? power_event_output : host_enable;
      if (x === 1'b1) return;
    end
    fail_count++;
    conclude();
  endtask
  task automatic do_reset(input logic [2:0] s);
    strap = s;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    chk("pins in reset", {pin_oe, pin_o}, 16'h0038);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    {reg_wr_en, reg_rd_en, energy_present, autoneg_enabled} = 4'h0;
    {cable_link_up, power_save_ctrl_bit, reg_addr, reg_wdata} = 26'h0;
    {led_drive, eeprom_data_drive, eeprom_clock_drive} = 3'h7;
    do_reset(3'b010);
    rdc("ccr", OFS_CHIP_CONFIGURATION, 16'h0280);
    chk("eeprom", eeprom_present, 1'b1);
    chk("pins", {pin_oe, pin_o}, 16'h0007);
    strap = 3'b101;
    repeat (3) @(negedge clk);
    chk("bus16", bus_is_16bit, 1'b0);
    do_reset(3'b101);
    rdc("ccr", OFS_CHIP_CONFIGURATION, 16'h0440);
    chk("endian", big_endian, 1'b1);
    do_reset(3'b000);
    rdc("pmc", PMC, 16'h0000);
    wr(OFS_RECEIVE_FRAME_POINTER, 16'h0800);
    chk("endian", big_endian, 1'b1);
    wr(PMC, 16'h0003);
    autoneg_enabled = 1'b1;
    power_save_ctrl_bit = 1'b1;
    @(negedge clk);
    chk("rxoff", rx_unused_off, 1'b1);
    chk("on", {traffic_enable, pll_enable, host_enable, mac_enable}, 16'h0007);
    cable_link_up = 1'b1;
    @(negedge clk);
    chk("rxoff", rx_unused_off, 1'b0);
    {cable_link_up, power_save_ctrl_bit} = 2'b00;
    wr(PMC, 16'h0000);
    chk("traffic", traffic_enable, 1'b1);
    wr(OFS_INTERRUPT_ENABLE, 16'h0004);
    wr(PMC, 16'h0002);
    chk("soft", {pll_enable, host_enable, phy_enable}, 16'h0000);
    wr(OFS_INTERRUPT_ENABLE, 16'h0000);
    rd(OFS_GLOBAL_RESET_CONTROL);
    wt(2);
    chk("phy", phy_enable, 1'b1);
    rdc("pmc", PMC, 16'h0000);
    rdc("ier", OFS_INTERRUPT_ENABLE, 16'h0004);
    energy_present = 1'b1;
    wr(OFS_SLEEP_WAKE_TIMING, 16'h0201);
    wr(PMC, 16'h0101);
    energy_present = 1'b0;
    repeat (TK - 1) @(negedge clk);
    chk("early", energy_sense_only, 1'b0);
    wt(0);
    chk("sleep", {pll_enable, traffic_enable}, 16'h0000);
    energy_present = 1'b1;
    repeat (2 * TK) @(negedge clk);
    chk("wake early", {power_event_output, energy_sense_only}, 16'h0001);
    wt(1);
    chk("irq", energy_irq, 1'b1);
    chk("stay", energy_sense_only, 1'b1);
    rd(OFS_GLOBAL_RESET_CONTROL);
    wt(2);
    chk("traffic", traffic_enable, 1'b1);
    rdc("pmc", PMC, 16'h0105);
    wr(PMC, 16'h0145);
    chk("pme", power_event_output, 1'b0);
    energy_present = 1'b0;
    wt(0);
    energy_present = 1'b1;
    wt(2);
    rdc("pmc", PMC, 16'h0144);
    conclude();
  end
endmodule
